// File: snp_flash_seq.sv
`timescale 1ns/1ps
module snp_flash_seq
  import snp_pkg::*;
#(
  parameter int unsigned NUM_PAGES = 128,
  parameter int unsigned ERASE_NS  = 20000,
  parameter int unsigned PROG_NS   = 10000,
  parameter int unsigned READ_NS   = 10000,
  parameter int unsigned TW        = 24
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic [3:0] io_i,
  input  wire logic       wel_set_i,
  input  wire logic       wel_clr_i,
  input  wire logic       ecc_wr_i,
  input  wire logic       ecc_wdata_i,
  input  wire logic       buffer_mode_select_i,
  input  wire logic       top_bottom_select_i,
  input  wire logic [3:0] block_protect_bits_i,
  input  wire logic       wp_enable_i,
  output logic            so_o,
  output logic            so_oe_o,
  output logic            busy_o,
  output logic            write_enable_latch_o,
  output logic            ecc_enable_o
);
  localparam int unsigned PW = $clog2(NUM_PAGES);
  localparam int unsigned MW = $clog2(NUM_PAGES * PAGE_BYTES);
  localparam int unsigned NB = NUM_PAGES / BLK_PAGES;
  localparam int unsigned ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PROG_RAW  = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_RAW  = (READ_NS + CLK_NS - 1) / CLK_NS;
  // the byte walk needs a page worth of cycles, so short times are stretched
  localparam int unsigned PROG_CYC = PROG_RAW > PAGE_BYTES ? PROG_RAW : PAGE_BYTES + 1;
  localparam int unsigned READ_CYC = READ_RAW > PAGE_BYTES ? READ_RAW : PAGE_BYTES + 1;

  logic [5:0] s1_reg, s2_reg;
  logic       sck3_reg, cs3_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_reg   <= 6'h01;
      s2_reg   <= 6'h01;
      sck3_reg <= 1'b0;
      cs3_reg  <= 1'b1;
    end else if (ce_i) begin
      s1_reg   <= {io_i, sclk_i, cs_n_i};
      s2_reg   <= s1_reg;
      sck3_reg <= s2_reg[1];
      cs3_reg  <= s2_reg[0];
    end
  end
  wire       cs_s     = s2_reg[0];
  wire [3:0] io_s     = s2_reg[5:2];
  wire       sck_rise = s2_reg[1] & ~sck3_reg;
  wire       sck_fall = ~s2_reg[1] & sck3_reg;
  wire       cs_rise  = cs_s & ~cs3_reg;

  logic [7:0]            buf_mem [PAGE_BYTES];
  logic [7:0]            arr     [NUM_PAGES * PAGE_BYTES];
  logic [PAGE_BYTES-1:0] vld_reg;
  logic [NUM_PAGES-1:0]  blank_reg;

  function automatic logic [7:0] buf_rd(input logic [11:0] c);
    buf_rd = (c < PAGE_END && vld_reg[c]) ? buf_mem[c] : BYTE_ERASED;
  endfunction : buf_rd
  function automatic logic [7:0] arr_rd(input logic [PW-1:0] p, input logic [11:0] c);
    arr_rd = blank_reg[p] ? BYTE_ERASED : arr[MW'(p * PAGE_BYTES + c)];
  endfunction : arr_rd
  function automatic logic is_prot(input logic [PW-1:0] p);
    int unsigned blk;
    int unsigned n;
    blk = int'(p) >> BLK_SHIFT;
    n = 1 << (int'(block_protect_bits_i) - 1);
    if (block_protect_bits_i == 4'h0) is_prot = 1'b0;
    else if (n >= NB) is_prot = 1'b1;
    else if (top_bottom_select_i) is_prot = blk < n;
    else is_prot = blk >= NB - n;
  endfunction : is_prot

  snp_frame_t     fst_reg, fst_next;
  snp_run_t       run_reg, run_next;
  logic [4:0]     cnt_reg, cnt_next;
  logic [15:0]    sr_reg, sr_next, addr_reg, addr_next;
  logic [7:0]     op_reg, op_next, par_reg, par_next;
  logic [11:0]    col_reg, col_next, idx_reg, idx_next;
  logic [PW-1:0]  rdpg_reg, rdpg_next, pg_reg, pg_next, last_reg, last_next;
  logic           rdm_reg, rdm_next, so_reg, so_next, oe_reg, oe_next;
  logic           busy_reg, busy_next, wel_reg, wel_next, ecc_reg, ecc_next;
  logic [TW-1:0]  tmr_reg, tmr_next, dur;
  logic           ld_we, vclr, vset, blk_set, go, go_erase, go_prog, go_read, done;
  logic           quad, aw_en, bw_en;
  logic [7:0]     ld_dat, aw_dat, bw_dat, cur;
  logic [11:0]    bw_col;
  logic [PW-1:0]  pa;

  always_comb begin
    fst_next  = fst_reg;
    cnt_next  = cnt_reg;
    sr_next   = sr_reg;
    op_next   = op_reg;
    addr_next = addr_reg;
    col_next  = col_reg;
    rdpg_next = rdpg_reg;
    rdm_next  = rdm_reg;
    so_next   = so_reg;
    oe_next   = oe_reg;
    ld_we     = 1'b0;
    ld_dat    = {sr_reg[6:0], io_s[0]};
    vclr      = 1'b0;
    quad      = (op_reg == CMD_QLOAD) || (op_reg == CMD_QRLOAD);
    cur       = rdm_reg ? arr_rd(rdpg_reg, col_reg) : buf_rd(col_reg);
    if (quad) ld_dat = {sr_reg[3:0], io_s};
    if (cs_s) begin
      fst_next = ST_CMD;
      cnt_next = 5'h00;
      oe_next  = 1'b0;
    end else if (sck_rise) begin
      sr_next  = {sr_reg[14:0], io_s[0]};
      cnt_next = cnt_reg + 5'h01;
      unique case (fst_reg)
        ST_CMD: if (cnt_reg == CMD_LAST) begin
          op_next  = sr_next[7:0];
          cnt_next = 5'h00;
          fst_next = ST_IGNORE;
          if (!busy_reg) begin
            unique case (sr_next[7:0])
              CMD_ERASE, CMD_PEXEC, CMD_PREAD: fst_next = ST_DUMMY;
              CMD_LOAD, CMD_RLOAD: if (wel_reg) fst_next = ST_ADDR;
              CMD_QLOAD, CMD_QRLOAD: if (wel_reg && !wp_enable_i) fst_next = ST_ADDR;
              CMD_READ: fst_next = ST_ADDR;
              default: fst_next = ST_IGNORE;
            endcase
          end
        end
        ST_DUMMY: if (cnt_reg == DUMMY_LAST) begin
          fst_next = ST_ADDR;
          cnt_next = 5'h00;
        end
        ST_ADDR: if (cnt_reg == ADDR_LAST) begin
          addr_next = sr_next;
          cnt_next  = 5'h00;
          col_next  = sr_next[11:0];
          if (op_reg == CMD_READ) fst_next = ST_RD_DUMMY;
          else if (op_reg == CMD_ERASE || op_reg == CMD_PEXEC || op_reg == CMD_PREAD) fst_next = ST_WAIT_CS;
          else begin
            fst_next = ST_DATA_IN;
            vclr = (op_reg == CMD_LOAD) || (op_reg == CMD_QLOAD);
          end
        end
        ST_DATA_IN: begin
          if (quad) sr_next = {sr_reg[11:0], io_s};
          if (cnt_reg == (quad ? QUAD_LAST : SER_LAST)) begin
            cnt_next = 5'h00;
            if (col_reg < PAGE_END) begin
              ld_we    = 1'b1;
              col_next = col_reg + 12'h001;
            end
          end
        end
        ST_RD_DUMMY: if (cnt_reg == (buffer_mode_select_i ? RDB_LAST : RDC_LAST)) begin
          fst_next  = ST_DATA_OUT;
          cnt_next  = 5'h00;
          rdpg_next = last_reg;
          rdm_next  = 1'b0;
          col_next  = buffer_mode_select_i ? addr_reg[11:0] : 12'h000;
        end
        ST_WAIT_CS: fst_next = ST_IGNORE;
        ST_DATA_OUT, ST_IGNORE: cnt_next = cnt_reg;
      endcase
    end else if (sck_fall && fst_reg == ST_DATA_OUT) begin
      if (col_reg == PAGE_END) oe_next = 1'b0;
      else begin
        so_next  = cur[~cnt_reg[2:0]];
        oe_next  = 1'b1;
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == SER_LAST) begin
          cnt_next = 5'h00;
          col_next = col_reg + 12'h001;
          if (col_reg == PAGE_LAST && buffer_mode_select_i) col_next = PAGE_END;
          else if (col_reg == PAGE_LAST) begin
            col_next  = 12'h000;
            rdpg_next = rdpg_reg + PW'(1);
            rdm_next  = 1'b1;
          end
        end
      end
    end
  end

  always_comb begin
    pa       = addr_reg[PW-1:0];
    go       = cs_rise && fst_reg == ST_WAIT_CS && !busy_reg;
    go_erase = go && op_reg == CMD_ERASE && wel_reg && !is_prot(pa);
    go_prog  = go && op_reg == CMD_PEXEC && wel_reg && !is_prot(pa);
    go_read  = go && op_reg == CMD_PREAD;
    unique case (run_reg)
      RUN_ERASE: dur = TW'(ERASE_CYC - 1);
      RUN_PROG:  dur = TW'(PROG_CYC - 1);
      RUN_READ:  dur = TW'(READ_CYC - 1);
      RUN_IDLE:  dur = '0;
    endcase
    done      = run_reg != RUN_IDLE && tmr_reg == dur;
    run_next  = run_reg;
    tmr_next  = run_reg != RUN_IDLE ? tmr_reg + TW'(1) : tmr_reg;
    idx_next  = idx_reg;
    pg_next   = pg_reg;
    last_next = last_reg;
    par_next  = par_reg;
    vset      = go_read;
    blk_set   = done && run_reg == RUN_ERASE;
    aw_en     = run_reg == RUN_PROG && idx_reg != PAGE_END;
    aw_dat    = buf_rd(idx_reg);
    if (ecc_reg && idx_reg >= MAIN_END && idx_reg[ECC_POS_BIT]) aw_dat = par_reg;
    bw_en     = ld_we || (run_reg == RUN_READ && idx_reg != PAGE_END);
    bw_col    = ld_we ? col_reg : idx_reg;
    bw_dat    = ld_we ? ld_dat : arr_rd(pg_reg, idx_reg);
    if (aw_en && idx_reg < MAIN_END) par_next = par_reg ^ aw_dat;
    if (idx_reg != PAGE_END) idx_next = idx_reg + 12'h001;
    if (done) run_next = RUN_IDLE;
    if (go_erase || go_prog || go_read) begin
      run_next = go_erase ? RUN_ERASE : (go_prog ? RUN_PROG : RUN_READ);
      tmr_next = '0;
      idx_next = 12'h000;
      par_next = 8'h00;
      pg_next  = pa;
    end
    if (go_read) last_next = pa;
    busy_next = run_next != RUN_IDLE;
    wel_next  = wel_reg;
    if (wel_set_i) wel_next = 1'b1;
    else if (wel_clr_i || (done && run_reg != RUN_READ)) wel_next = 1'b0;
    ecc_next = ecc_wr_i ? ecc_wdata_i : ecc_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fst_reg  <= ST_CMD;
      run_reg  <= RUN_IDLE;
      cnt_reg  <= 5'h00;
      sr_reg   <= 16'h0000;
      addr_reg <= 16'h0000;
      op_reg   <= 8'h00;
      par_reg  <= 8'h00;
      col_reg  <= 12'h000;
      idx_reg  <= 12'h000;
      rdpg_reg <= '0;
      pg_reg   <= '0;
      last_reg <= '0;
      rdm_reg  <= 1'b0;
      so_reg   <= 1'b0;
      oe_reg   <= 1'b0;
      busy_reg <= 1'b0;
      wel_reg  <= 1'b0;
      ecc_reg  <= 1'b1;
      tmr_reg  <= '0;
    end else if (ce_i) begin
      fst_reg  <= fst_next;
      run_reg  <= run_next;
      cnt_reg  <= cnt_next;
      sr_reg   <= sr_next;
      addr_reg <= addr_next;
      op_reg   <= op_next;
      par_reg  <= par_next;
      col_reg  <= col_next;
      idx_reg  <= idx_next;
      rdpg_reg <= rdpg_next;
      pg_reg   <= pg_next;
      last_reg <= last_next;
      rdm_reg  <= rdm_next;
      so_reg   <= so_next;
      oe_reg   <= oe_next;
      busy_reg <= busy_next;
      wel_reg  <= wel_next;
      ecc_reg  <= ecc_next;
      tmr_reg  <= tmr_next;
    end
  end

  // erased pages are a flag, so an erase costs no byte walk
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vld_reg   <= '0;
      blank_reg <= '1;
    end else if (ce_i) begin
      if (vclr) vld_reg <= '0;
      if (vset) vld_reg <= '1;
      if (ld_we) vld_reg[col_reg] <= 1'b1;
      if (go_prog) blank_reg[pa] <= 1'b0;
      for (int j = 0; j < BLK_PAGES; j++) begin
        if (blk_set) blank_reg[PW'(((int'(pg_reg) >> BLK_SHIFT) << BLK_SHIFT) + j)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && aw_en) arr[MW'(pg_reg * PAGE_BYTES + idx_reg)] <= aw_dat;
    if (ce_i && bw_en) buf_mem[bw_col] <= bw_dat;
  end

  assign so_o                 = so_reg;
  assign so_oe_o              = oe_reg;
  assign busy_o               = busy_reg;
  assign write_enable_latch_o = wel_reg;
  assign ecc_enable_o         = ecc_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  erase_needs_wel_a: assert property (ce_i && go && op_reg == CMD_ERASE && !wel_reg |=> !busy_reg)
    else $error("erase started without write enable");
  erase_boundary_a: assert property ($rose(busy_reg) |-> $past(fst_reg) == ST_WAIT_CS)
    else $error("operation started off a byte boundary");
  erase_busy_a: assert property ($rose(busy_reg) && run_reg == RUN_ERASE |-> busy_reg [*8])
    else $error("erase busy dropped early");
  wel_clear_a: assert property (ce_i && done && run_reg != RUN_READ && !wel_set_i |=> !wel_reg)
    else $error("write enable not cleared after operation");
  prot_block_a: assert property ((go_erase || go_prog) |-> !is_prot(pa))
    else $error("protected block or page accepted");
  load_bound_a: assert property (ld_we |-> col_reg < PAGE_END)
    else $error("load wrote past buffer end");
  quad_wp_a: assert property (fst_reg == ST_CMD && fst_next == ST_ADDR && quad_op(sr_next[7:0]) |-> !wp_enable_i)
    else $error("quad load accepted under write protect");
  read_busy_a: assert property ($rose(busy_reg) && run_reg == RUN_READ |-> busy_reg [*8] ##0 !wel_clr_i || busy_reg)
    else $error("page read busy dropped early");
  buf_end_a: assert property (ce_i && fst_reg == ST_DATA_OUT && sck_fall && !cs_s && col_reg == PAGE_END |=> !oe_reg)
    else $error("output driven past buffer end");
  ecc_reset_a: assert property ($past(!rst_n_i) |-> ecc_reg)
    else $error("ecc enable not set after reset");
  function automatic logic quad_op(input logic [7:0] o);
    quad_op = (o == CMD_QLOAD) || (o == CMD_QRLOAD);
  endfunction : quad_op
  erase_done_c: cover property (run_reg == RUN_ERASE && done);
  load_byte_c: cover property (ld_we && quad);
  read_out_c: cover property (fst_reg == ST_DATA_OUT && oe_reg);
  cont_wrap_c: cover property ($rose(rdm_reg));
endmodule : snp_flash_seq

// File: snp_pkg.sv
package snp_pkg;
  localparam logic [7:0]  CMD_ERASE   = 8'hD8;
  localparam logic [7:0]  CMD_LOAD    = 8'h02;
  localparam logic [7:0]  CMD_RLOAD   = 8'h84;
  localparam logic [7:0]  CMD_QLOAD   = 8'h32;
  localparam logic [7:0]  CMD_QRLOAD  = 8'h34;
  localparam logic [7:0]  CMD_PEXEC   = 8'h10;
  localparam logic [7:0]  CMD_PREAD   = 8'h13;
  localparam logic [7:0]  CMD_READ    = 8'h03;
  localparam logic [7:0]  BYTE_ERASED = 8'hFF;
  localparam int unsigned PAGE_BYTES  = 2112;
  localparam int unsigned BLK_PAGES   = 64;
  localparam int unsigned BLK_SHIFT   = 6;
  localparam int unsigned ECC_POS_BIT = 3;
  localparam int unsigned CLK_NS      = 4;
  localparam logic [11:0] PAGE_END    = 12'h0840;
  localparam logic [11:0] PAGE_LAST   = 12'h083F;
  localparam logic [11:0] MAIN_END    = 12'h0800;
  localparam logic [4:0]  CMD_LAST    = 5'h07;
  localparam logic [4:0]  DUMMY_LAST  = 5'h07;
  localparam logic [4:0]  ADDR_LAST   = 5'h0F;
  localparam logic [4:0]  RDB_LAST    = 5'h07;
  localparam logic [4:0]  RDC_LAST    = 5'h17;
  localparam logic [4:0]  SER_LAST    = 5'h07;
  localparam logic [4:0]  QUAD_LAST   = 5'h01;
  typedef enum logic [2:0] {
    ST_CMD, ST_DUMMY, ST_ADDR, ST_DATA_IN, ST_RD_DUMMY, ST_DATA_OUT, ST_WAIT_CS, ST_IGNORE
  } snp_frame_t;
  typedef enum logic [1:0] {RUN_IDLE, RUN_ERASE, RUN_PROG, RUN_READ} snp_run_t;
endpackage : snp_pkg

// File: snp_host_model.sv
`timescale 1ns/1ps
module snp_host_model (
  input  wire logic       so_i,
  input  wire logic       so_oe_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic [3:0]      io_o
);
  localparam time HALF = 24;
  // sclk stands low outside frames; bits change while sclk is low
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o   = 4'h0;
  end
  task automatic tick();
    #HALF sclk_o = 1'b1;
    #HALF sclk_o = 1'b0;
  endtask : tick
  // quad sends high nibble first with io[3] as msb
  task automatic put(input logic [7:0] b, input logic quad);
    if (quad) begin
      io_o = b[7:4];
      tick();
      io_o = b[3:0];
      tick();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        io_o[0] = b[i];
        tick();
      end
    end
  endtask : put
  // sampled on the rise, half a period after the device drove it
  task automatic get(output logic [7:0] b, output logic oe);
    oe = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #HALF sclk_o = 1'b1;
      b[i] = so_i;
      oe   = oe & so_oe_i;
      #HALF sclk_o = 1'b0;
    end
  endtask : get
  task automatic frame_open(input logic [7:0] op);
    cs_n_o = 1'b0;
    #HALF;
    put(op, 1'b0);
  endtask : frame_open
  // released io lines flip so a stale level cannot pass for data
  task automatic frame_close();
    #HALF cs_n_o = 1'b1;
    io_o = ~io_o;
    #(4 * HALF);
  endtask : frame_close
endmodule : snp_host_model

// File: snp_flash_seq_tb.sv
`timescale 1ns/1ps
module snp_flash_seq_tb;
  import snp_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] col;
    logic [7:0]  data;
    logic [15:0] rcol;
    logic [15:0] exp;
  } snp_row_t;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cs_n, sclk, so, soe, busy, write_enable_latch, ecc;
  logic [3:0] io;
  logic       wel_set = 1'b0, wel_clr = 1'b0, ecc_wr = 1'b0, bm = 1'b1, tbs = 1'b0, wp = 1'b0;
  logic       ce = 1'b1, ecc_wdata = 1'b0;
  logic [3:0] bp = 4'h0;
  logic [7:0] b0, b1;
  logic       oe;
  int         fail_count = 0, n_compared = 0, bcnt = 0, cyc = 0;
  snp_row_t   rows [4] = '{
    '{CMD_LOAD,   16'h0830, 8'h3C, 16'h082F, 16'hFF3C},
    '{CMD_RLOAD,  16'hF831, 8'h5A, 16'h0830, 16'h3C5A},
    '{CMD_QRLOAD, 16'h0832, 8'hC3, 16'h0831, 16'h5AC3},
    '{CMD_QLOAD,  16'h0832, 8'h96, 16'h0831, 16'hFF96}};
  snp_flash_seq #(.NUM_PAGES(128), .ERASE_NS(400), .PROG_NS(0), .READ_NS(0)) snp_flash_seq_inst (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .cs_n_i(cs_n), .sclk_i(sclk), .io_i(io),
    .wel_set_i(wel_set), .wel_clr_i(wel_clr), .ecc_wr_i(ecc_wr), .ecc_wdata_i(ecc_wdata),
    .buffer_mode_select_i(bm), .top_bottom_select_i(tbs), .block_protect_bits_i(bp),
    .wp_enable_i(wp), .so_o(so), .so_oe_o(soe), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
    .ecc_enable_o(ecc));
  snp_host_model snp_host_model_inst (
    .so_i(so), .so_oe_i(soe), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) bcnt <= bcnt + 1;
    // well above the ~21k cycles the sequence needs
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  task automatic load(input logic [7:0] op, input logic [15:0] col, input logic [15:0] d, input int n);
    snp_host_model_inst.frame_open(op);
    snp_host_model_inst.put(col[15:8], 1'b0);
    snp_host_model_inst.put(col[7:0], 1'b0);
    for (int i = 0; i < n; i++)
      snp_host_model_inst.put(i == 0 ? d[15:8] : d[7:0], op == CMD_QLOAD || op == CMD_QRLOAD);
    snp_host_model_inst.frame_close();
  endtask : load
  // page commands; extra adds one stray clock after the address
  task automatic cmd3(input logic [7:0] op, input logic [15:0] pa, input logic extra);
    @(negedge clk) bcnt = 0;
    snp_host_model_inst.frame_open(op);
    snp_host_model_inst.put(8'h00, 1'b0);
    snp_host_model_inst.put(pa[15:8], 1'b0);
    snp_host_model_inst.put(pa[7:0], 1'b0);
    if (extra) snp_host_model_inst.tick();
    snp_host_model_inst.frame_close();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
  endtask : cmd3
  task automatic rd(input logic [15:0] col);
    snp_host_model_inst.frame_open(CMD_READ);
    snp_host_model_inst.put(col[15:8], 1'b0);
    snp_host_model_inst.put(col[7:0], 1'b0);
    for (int i = 0; i < (bm ? 1 : 3); i++) snp_host_model_inst.put(8'h00, 1'b0);
    snp_host_model_inst.get(b0, oe);
    snp_host_model_inst.get(b1, oe);
    snp_host_model_inst.frame_close();
  endtask : rd
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({12'h000, write_enable_latch, ecc, busy, soe}, 16'h0004);
    foreach (rows[r]) begin
      pulse(wel_set);
      load(rows[r].op, rows[r].col, {rows[r].data, 8'h00}, 1);
      rd(rows[r].rcol);
      chk({b0, b1}, rows[r].exp);
    end
    pulse(wel_clr);
    load(CMD_LOAD, 16'h0830, 16'h1100, 1);
    rd(16'h0830);
    chk({b0, b1}, 16'hFFFF);
    pulse(wel_set);
    @(negedge clk) wp = 1'b1;
    load(CMD_QLOAD, 16'h0830, 16'h2200, 1);
    @(negedge clk) wp = 1'b0;
    rd(16'h0830);
    chk({b0, b1}, 16'hFFFF);
    pulse(wel_set);
    load(CMD_RLOAD, 16'h083F, 16'h7700, 2);
    rd(16'h083F);
    chk({b0, 7'h00, oe}, 16'h7700);
    rd(16'h0000);
    chk({8'h00, b0}, 16'h00FF);
    // one program of page 5 only, keeping the host's page order
    pulse(wel_set);
    load(CMD_LOAD, 16'h0000, 16'h8100, 1);
    pulse(wel_set);
    cmd3(CMD_PEXEC, 16'h0005, 1'b0);
    chk({15'h0000, bcnt >= 2113}, 16'h0001);
    chk({15'h0000, write_enable_latch}, 16'h0000);
    pulse(wel_set);
    load(CMD_LOAD, 16'h0830, 16'h0000, 1);
    cmd3(CMD_PREAD, 16'h0005, 1'b0);
    chk({15'h0000, bcnt >= 2113}, 16'h0001);
    rd(16'h0837);
    chk({b0, b1}, 16'hFF7E);
    @(negedge clk) bm = 1'b0;
    rd(16'h0400);
    chk({b0, b1}, 16'h81FF);
    @(negedge clk) bm = 1'b1;
    pulse(wel_clr);
    cmd3(CMD_ERASE, 16'h0005, 1'b0);
    chk(16'(bcnt), 16'h0000);
    pulse(wel_set);
    cmd3(CMD_ERASE, 16'h0005, 1'b1);
    chk(16'(bcnt), 16'h0000);
    @(negedge clk) bp = 4'h1;
    cmd3(CMD_ERASE, 16'h0040, 1'b0);
    chk(16'(bcnt), 16'h0000);
    cmd3(CMD_PEXEC, 16'h0041, 1'b0);
    chk(16'(bcnt), 16'h0000);
    // bottom-side protection now covers block 0
    @(negedge clk) tbs = 1'b1;
    cmd3(CMD_ERASE, 16'h0005, 1'b0);
    chk(16'(bcnt), 16'h0000);
    @(negedge clk) tbs = 1'b0;
    @(negedge clk) bp = 4'h0;
    cmd3(CMD_ERASE, 16'h0005, 1'b0);
    chk(16'(bcnt), 16'h0064);
    chk({15'h0000, write_enable_latch}, 16'h0000);
    cmd3(CMD_PREAD, 16'h0005, 1'b0);
    rd(16'h0836);
    chk({b0, b1}, 16'hFFFF);
    pulse(ecc_wr);
    chk({15'h0000, ecc}, 16'h0000);
    // a frozen block must ignore the latch-set event
    @(negedge clk) ce = 1'b0;
    pulse(wel_set);
    chk({15'h0000, write_enable_latch}, 16'h0000);
    @(negedge clk) ce = 1'b1;
    pulse(wel_set);
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk) rst_n = 1'b1;
    chk({12'h000, write_enable_latch, ecc, busy, soe}, 16'h0004);
    complete_run();
  end
endmodule : snp_flash_seq_tb
